// ==== rtl/dhp_port.v ====
// Host register port with strap selected bus style and internal byte memory
`timescale 1ns/1ps
`include "dhp_defines.vh"
// Behaviour
// - Eight bit address selects memory location
// - Eight bit data, driven only on reads
// - Interrupt high in ready style, low acknowledge
// - Style strap high means acknowledge style
// - Transfers timed by processor clock rising edge
// - Read pin: read strobe or direction line
// - Open drain done: ready high or acknowledge low
// - Strobes ignored while select is high
module dhp_port (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Host pins
  input wire i_pclk,
  input wire [7:0] i_addr,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output reg o_data_oe,
  input wire i_sel_n,
  input wire i_rd,
  input wire i_wr_n,
  input wire i_bus_style_select,
  output reg o_transfer_done_out,
  output reg o_transfer_done_out_oe,
  output reg o_int,
  // Internal interrupt request from the device core
  input wire i_int_req
);
  wire [20:0] pins_s;
  wire pclk_s;
  wire [7:0] addr_s;
  wire [7:0] data_s;
  wire sel_n_s;
  wire rd_s;
  wire wr_n_s;
  wire style_s;
  reg pclk_q;
  reg style_q;
  reg [1:0] state_q;
  reg is_read_q;
  reg [7:0] addr_q;
  reg [7:0] mem_q [0:`DHP_MEM_DEPTH-1];
  wire pclk_rise;
  wire req_read;
  wire req_write;
  wire req_active;
  integer i;

  // Every host pin crosses two flops before any logic looks at it
  dhp_sync #(.W(21)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_pclk, i_addr, i_data, i_sel_n, i_rd, i_wr_n, i_bus_style_select}),
    .o_sync(pins_s)
  );

  assign pclk_s = pins_s[20];
  assign addr_s = pins_s[19:12];
  assign data_s = pins_s[11:4];
  assign sel_n_s = pins_s[3];
  assign rd_s = pins_s[2];
  assign wr_n_s = pins_s[1];
  assign style_s = pins_s[0];

  // Sampling edge of the processor clock
  assign pclk_rise = pclk_s & ~pclk_q;

  // How an access runs through this port:
  //   IDLE  waits for a processor clock rise with select low and a valid
  //         strobe, then latches the address and the direction.
  //   WAIT  waits for the next processor clock rise; a write stores the
  //         byte there, because the host holds data stable until done.
  //   DONE  gives the memory one cycle so the read word is settled
  //         before completion is shown on the pin.
  //   END   shows completion and holds it until the host lets go of its
  //         strobe or select; only then can a new access be taken.
  // Every host pin is seen two system clocks late through the
  // synchroniser, so the processor clock must be slow against i_clk.
  // A limitation: the processor clock must stay low or high for longer than
  // one system clock, or an edge may be missed entirely.

  // Read request decode for either bus style
  function dec_read;
    input sel_n;
    input style;
    input rd;
    begin
      // Acknowledge style: read pin is direction, high reads
      // Ready style: read pin is an active low strobe
      dec_read = ~sel_n & (style ? rd : ~rd);
    end
  endfunction

  // Write request decode for either bus style
  function dec_write;
    input sel_n;
    input style;
    input rd;
    input wr_n;
    begin
      // The write pin is ignored in acknowledge style, the host keeps it
      // high there; in ready style the read strobe must be idle as well so
      // a glitch that shows both strobes is not taken as a write
      dec_write = ~sel_n & (style ? ~rd : (~wr_n & rd));
    end
  endfunction

  // True while an access has been taken and not yet returned to idle
  function in_access;
    input [1:0] state;
    begin
      in_access = (state != `DHP_ST_IDLE);
    end
  endfunction

  // True while completion is shown to the host
  function at_end;
    input [1:0] state;
    begin
      at_end = (state == `DHP_ST_END);
    end
  endfunction

  // Decode strobes per bus style; select gates everything
  assign req_read = dec_read(sel_n_s, style_q, rd_s);
  assign req_write = dec_write(sel_n_s, style_q, rd_s, wr_n_s);
  assign req_active = req_read | req_write;

  // Clock edge tracking and strap capture; the strap is taken while idle
  // so a change mid-access cannot flip the polarity of a live handshake
  always @(posedge i_clk) begin
    if (i_reset) begin
      pclk_q <= 1'b0;
      style_q <= 1'b0;
    end else begin
      pclk_q <= pclk_s;
      if (state_q == `DHP_ST_IDLE) begin
        style_q <= style_s;
      end
    end
  end

  // Access sequencer: accept, complete, then wait for the host to end it
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= `DHP_ST_IDLE;
      is_read_q <= 1'b0;
      addr_q <= 8'h00;
      for (i = 0; i < `DHP_MEM_DEPTH; i = i + 1) begin
        mem_q[i] <= `DHP_MEM_RESET;
      end
    end else begin
      case (state_q)
        `DHP_ST_IDLE: begin
          if (pclk_rise && req_active) begin
            addr_q <= addr_s;
            is_read_q <= req_read;
            state_q <= `DHP_ST_WAIT;
          end
        end
        `DHP_ST_WAIT: begin
          // Write data taken at the next clock edge, host holds it stable
          if (pclk_rise) begin
            if (!is_read_q) begin
              mem_q[addr_q] <= data_s;
            end
            state_q <= `DHP_ST_DONE;
          end
        end
        `DHP_ST_DONE: begin
          state_q <= `DHP_ST_END;
        end
        `DHP_ST_END: begin
          // Hold completion until the host drops its strobe or select
          if (!req_active) begin
            state_q <= `DHP_ST_IDLE;
          end
        end
        default: begin
          state_q <= `DHP_ST_IDLE;
        end
      endcase
    end
  end

  // Read data path: the word at the latched address is always presented,
  // only the enable decides whether the pins carry it
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data <= mem_q[addr_q];
      // Drive data only during an accepted read still held by select,
      // so a host that drops select early never fights the pins
      o_data_oe <= is_read_q && in_access(state_q) && !sel_n_s;
    end
  end

  // Completion pin: open drain, so the value is always low and only the
  // enable moves; the board pull-up gives the released level
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_transfer_done_out <= 1'b0;
      o_transfer_done_out_oe <= 1'b0;
    end else begin
      o_transfer_done_out <= 1'b0;
      if (style_q) begin
        // Acknowledge: pulled low only while done is shown and held
        o_transfer_done_out_oe <= at_end(state_q) && req_active;
      end else begin
        // Ready: pulled low while busy, released high once done
        o_transfer_done_out_oe <= in_access(state_q) && !at_end(state_q);
      end
    end
  end

  // Interrupt pin level follows the bus style polarity
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_int <= 1'b0;
    end else begin
      o_int <= style_q ? ~i_int_req : i_int_req;
    end
  end
endmodule

// ==== rtl/dhp_defines.vh ====
// Constants for the dual style host register port
`ifndef DHP_DEFINES_VH
`define DHP_DEFINES_VH
`define DHP_ADDR_W 8
`define DHP_DATA_W 8
`define DHP_MEM_DEPTH 256
`define DHP_MEM_RESET 8'h00
`define DHP_ST_IDLE 2'h0
`define DHP_ST_WAIT 2'h1
`define DHP_ST_DONE 2'h2
`define DHP_ST_END 2'h3
`endif

// ==== rtl/dhp_sync.v ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dhp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Asynchronous level in, synchronised level out
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage is read only by the second stage
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ==== sim/dhp_c_assertions.sv ====
// Pin checks for the host register port
`timescale 1ns/1ps
module dhp_c (
  input wire i_clk, i_reset, i_sel_n, i_rd, i_bus_style_select, i_int_req,
  input wire o_data_oe, o_transfer_done_out, o_transfer_done_out_oe, o_int
);
  wire s = i_bus_style_select;
  wire t = o_transfer_done_out_oe;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Outputs tied to strap, select and command
  int_pin_a: assert property (($stable(s) && $stable(i_int_req))[*4]
    |-> o_int == (i_int_req ^ s)) else $error("int");
  od_low_a: assert property (!o_transfer_done_out) else $error("od");
  rst_idle_a: assert property ($fell(i_reset) |-> !o_data_oe && !t) else $error("rst");
  drv_sel_a: assert property (o_data_oe |-> !$past(i_sel_n, 4)) else $error("drv");
  done_sel_a: assert property ($rose(t) |-> !$past(i_sel_n, 4)) else $error("done");
  rd_rdy_a: assert property ((!s && i_rd)[*5] |-> !o_data_oe) else $error("rdy");
  wr_ack_a: assert property ((s && !i_rd)[*5] |-> !o_data_oe) else $error("ack");
  sel_idle_a: assert property (i_sel_n[*8] |-> !t) else $error("idle");
endmodule
bind dhp_port dhp_c i_dhp_c (.*);

// ==== sim/dhp_h.sv ====
// Host processor model for the register port
`timescale 1ns/1ps
module dhp_h (
  input wire i_clk, o_data_oe, o_transfer_done_out_oe,
  input wire [7:0] o_data,
  output reg i_pclk, i_sel_n, i_rd, i_wr_n,
  output reg [7:0] i_addr, i_data
);
  wire t = o_transfer_done_out_oe;
  // Idle pins; pclk stands still between accesses
  initial {i_pclk, i_sel_n, i_rd, i_wr_n, i_addr, i_data} = 20'h70000;
  // Mode m is style, write, select; pins held until done shows
  task acc(input [2:0] m, input [7:0] a, d, output [7:0] q);
    reg b;
    begin
      @(negedge i_clk);
      {i_addr, i_data, i_sel_n, i_rd, i_wr_n} = {a, d, m[0], ^m[2:1], m[2] | !m[1]};
      b = 1'h0;
      repeat (12) if (!(m[2] ? t : b && !t)) begin
        #80 i_pclk = 1'h1;
        #80 i_pclk = 1'h0;
        b = b | t;
      end
      q = o_data_oe ? o_data : 8'hxx;
      {i_sel_n, i_rd, i_wr_n, i_data} = {3'h7, ~d};
      repeat (8) @(negedge i_clk);
    end
  endtask
endmodule

// ==== sim/test_dual_style_host_register_port.sv ====
// Bench for the host register port
`timescale 1ns/1ps
module test_dual_style_host_register_port;
  reg i_clk = 1'h0, i_reset = 1'h1, i_bus_style_select = 1'h0, i_int_req = 1'h1;
  wire i_pclk, i_sel_n, i_rd, i_wr_n, o_data_oe, o_transfer_done_out, o_transfer_done_out_oe;
  wire o_int;
  wire [7:0] i_addr, i_data, o_data;
  reg [7:0] q;
  integer num_errors = 0, total_checks = 0;
  dhp_port i_dhp_port (.*);
  dhp_h i_dhp_h (.*);
  // Compare and count
  task chk(input [23:0] n, input [7:0] s, e);
    begin
      total_checks++;
      if (s !== e) begin
        num_errors++;
        $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task t_ready;
    begin
      i_dhp_h.acc(3'h2, 8'h01, 8'ha5, q);
      i_dhp_h.acc(3'h0, 8'h01, 8'h00, q);
      chk("rd", q, 8'ha5);
      chk("int", {7'h00, o_int}, 8'h01);
      chk("odv", {7'h00, o_transfer_done_out}, 8'h00);
      chk("rdy", {7'h00, o_transfer_done_out_oe}, 8'h00);
      chk("oe", {7'h00, o_data_oe}, 8'h00);
      $display("ready done");
    end
  endtask
  task t_ack;
    begin
      i_bus_style_select = 1'h1;
      i_dhp_h.acc(3'h6, 8'hfe, 8'hc3, q);
      i_dhp_h.acc(3'h7, 8'hfe, 8'h3c, q);
      i_dhp_h.acc(3'h4, 8'hfe, 8'h00, q);
      chk("sel", q, 8'hc3);
      chk("int", {7'h00, o_int}, 8'h00);
      chk("ack", {7'h00, o_transfer_done_out_oe}, 8'h00);
      chk("oe", {7'h00, o_data_oe}, 8'h00);
      $display("ack done");
    end
  endtask
  // Clock, reset, tests and watchdog
  initial forever #10 i_clk = ~i_clk;
  initial begin
    repeat (5) @(negedge i_clk);
    i_reset = 1'h0;
    #200 t_ready;
    t_ack;
    wrap_up;
  end
  initial begin
    #60000 num_errors++;
    wrap_up;
  end
endmodule
